/* adc_ctrl_checker.sv */
// port assertions for the converter control block
`timescale 1ns/1ps
module adc_ctrl_checker (
   // bus
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_awvalid,
   input wire logic        s_awready,
   input wire logic        s_wvalid,
   input wire logic        s_wready,
   input wire logic        s_bvalid,
   input wire logic        s_bready,
   input wire logic [1:0]  s_bresp,
   input wire logic        s_arvalid,
   input wire logic        s_arready,
   input wire logic        s_rvalid,
   input wire logic        s_rready,
   input wire logic [31:0] s_rdata,
   // converter side
   input wire logic [4:0]  pos_mux_sel,
   input wire logic        pos_mux_valid,
   input wire logic [4:0]  neg_mux_sel,
   input wire logic        neg_mux_valid,
   input wire logic        sample_switch_closed,
   input wire logic        sar_start,
   input wire logic        conv_busy
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_awvalid && s_awready && s_wvalid && s_wready;
   endsequence
   sequence s_b_answer;
      ##2 s_bvalid;
   endsequence
   // switches held open and busy for three cycles after the start pulse
   sequence s_conv_open;
      (!sample_switch_closed && conv_busy) [*3];
   endsequence
   property p_b_time;
      s_wr_taken |-> s_b_answer;
   endproperty
   a_b_time: assert property (p_b_time)
      else $error("write answer off time");
   property p_b_hold;
      s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped");
   property p_r_time;
      s_arvalid && s_arready |=> s_rvalid;
   endproperty
   a_r_time: assert property (p_r_time)
      else $error("read answer off time");
   property p_r_hold;
      s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read answer dropped");
   property p_start_pulse;
      sar_start |=> !sar_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("start not a pulse");
   property p_conv_open;
      sar_start |=> s_conv_open;
   endproperty
   a_conv_open: assert property (p_conv_open)
      else $error("inputs not held open");
   property p_pos_code;
      pos_mux_valid |-> pos_mux_sel <= 5'h13;
   endproperty
   a_pos_code: assert property (p_pos_code)
      else $error("reserved positive code routed");
   property p_neg_code;
      neg_mux_valid |-> neg_mux_sel <= 5'h10;
   endproperty
   a_neg_code: assert property (p_neg_code)
      else $error("reserved negative code routed");
endmodule : adc_ctrl_checker

/* adc_ctrl_pkg.sv */
// constants, offsets and types shared by the converter control block
package adc_ctrl_pkg;
   // register byte offsets
   localparam logic [7:0] ctrl_off     = 8'h00;
   localparam logic [7:0] pos_sel_off  = 8'h04;
   localparam logic [7:0] neg_sel_off  = 8'h08;
   localparam logic [7:0] offset_off   = 8'h0c;
   localparam logic [7:0] gain_off     = 8'h10;
   localparam logic [7:0] ref_ctrl_off = 8'h14;
   localparam logic [7:0] result_off   = 8'h18;
   localparam logic [7:0] sw_start_off = 8'h1c;
   // field positions and widths
   localparam int chan_w     = 5;
   localparam int trim_w     = 10;
   localparam int mode_lsb   = 3;
   localparam int ref_pd_bit = 1;
   localparam int ref_out_bit = 0;
   // reset values
   localparam logic [7:0]  ctrl_rst  = 8'h00;
   localparam logic [4:0]  chan_rst  = 5'h00;
   localparam logic [9:0]  trim_rst  = 10'h000;
   localparam logic [1:0]  ref_rst   = 2'h0;
   // trim limits in quarter lsb: 3.125% and 3% of 4096 lsb
   localparam int lsb_full          = 4096;
   localparam logic signed [11:0] offset_lim_q = 12'sd512;
   localparam logic signed [11:0] gain_lim_q   = 12'sd491;
   // conversion length in clocks
   localparam int conv_cycles = 14;
   // trigger codes
   typedef enum logic [2:0] {
      trig_pin   = 3'h0,
      trig_tmr1  = 3'h1,
      trig_tmr0  = 3'h2,
      trig_single = 3'h3,
      trig_cont  = 3'h4,
      trig_logic = 3'h5
   } trig_t;
   typedef enum logic [1:0] {
      mode_single = 2'h0,
      mode_diff   = 2'h1,
      mode_pseudo = 2'h2
   } mode_t;
   // sampling source on negative side
   typedef enum logic [1:0] {
      neg_gnd = 2'h0,
      neg_pin = 2'h1,
      neg_ref = 2'h2
   } neg_src_t;
endpackage : adc_ctrl_pkg

/* adc_trigger_mux_calibration_ctrl.sv */
// What this block does
// - type 000 pin trigger, 001 timer one
// - 010 timer zero, 011 software, 100 continuous, 101 logic
// - positive code bits 4-0, inputs 0..15
// - positive 10000-10011 select internal sources
// - negative code 0..15 inputs, 10000 reference
// - offset trim, quarter lsb, 3.125% span
// - gain trim, quarter lsb, 3% span
// - conversion opens input switches until done
// - single-ended grounds negative sampling side
// - pseudo-differential negative pin then reference
// - reference bit 1 powers down internal
// - reference bit 0 drives reference pin
// - mode 00 single, 01 diff, 10 pseudo
`timescale 1ns/1ps
module adc_trigger_mux_calibration_ctrl
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // triggers
   input  wire logic        external_conversion_trigger_pin,
   input  wire logic        timer0_overflow,
   input  wire logic        timer1_overflow,
   input  wire logic        programmable_logic_array,
   // analog front end
   output logic [4:0]       pos_mux_sel,
   output logic             pos_mux_valid,
   output logic [4:0]       neg_mux_sel,
   output logic             neg_mux_valid,
   output logic [1:0]       neg_sample_src,
   output logic             sample_switch_closed,
   output logic             sar_start,
   input  wire logic        sar_done,
   input  wire logic [11:0] sar_code,
   output logic             int_ref_power_down,
   output logic             ref_pin_connect,
   output logic             conv_busy
);
   typedef enum logic [1:0] {
      st_acq  = 2'b00,
      st_conv = 2'b01,
      st_wait = 2'b11
   } state_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        aw_have;
      logic [7:0]  aw_addr;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  ctrl;
      logic [4:0]  pos_sel;
      logic [4:0]  neg_sel;
      logic [9:0]  offset;
      logic [9:0]  gain;
      logic [1:0]  refc;
      logic [11:0] result;
      logic        sw_req;
      logic        trig_d;
      state_t      st;
      logic [4:0]  cnt;
      logic        start;
      logic [1:0]  nsrc;
      logic [4:0]  pmux;
      logic        pval;
      logic [4:0]  nmux;
      logic        nval;
   } state_s_t;
   state_s_t r_reg;
   state_s_t r_next;
   trim_if tif ();
   trim_unit u_trim (
      .t (tif.unit)
   );
   assign tif.raw    = sar_code;
   assign tif.offset = r_reg.offset;
   assign tif.gain   = r_reg.gain;
   logic        trig_lvl;
   logic        trig_evt;
   logic [1:0]  mode;
   logic        do_wr;
   logic [7:0]  wa;
   logic [31:0] wd;
   always_comb
   begin
      r_next = r_reg;
      mode = r_reg.ctrl[mode_lsb +: 2];
      // trigger select; reserved codes never start
      case (trig_t'(r_reg.ctrl[2:0]))
         trig_pin:    trig_lvl = external_conversion_trigger_pin;
         trig_tmr1:   trig_lvl = timer1_overflow;
         trig_tmr0:   trig_lvl = timer0_overflow;
         trig_logic:  trig_lvl = programmable_logic_array;
         default:     trig_lvl = 1'b0;
      endcase
      r_next.trig_d = trig_lvl;
      trig_evt = trig_lvl & ~r_reg.trig_d;
      if (trig_t'(r_reg.ctrl[2:0]) == trig_single)
         trig_evt = r_reg.sw_req;
      if (trig_t'(r_reg.ctrl[2:0]) == trig_cont)
         trig_evt = 1'b1;
      // positive mux: 0..19 valid, others drop pos_mux_valid
      r_next.pmux = r_reg.pos_sel;
      r_next.pval = r_reg.pos_sel <= 5'h13;
      r_next.nmux = r_reg.neg_sel;
      r_next.nval = r_reg.neg_sel <= 5'h10;
      r_next.start = 1'b0;
      case (r_reg.st)
         st_acq:
         begin
            if (trig_evt && mode != 2'h3)
            begin
               r_next.st = st_conv;
               r_next.start = 1'b1;
               r_next.cnt = 5'(conv_cycles);
               r_next.sw_req = 1'b0;
            end
         end
         st_conv:
         begin
            // sar_done must come; the counter does not gate it
            if (r_reg.cnt != 5'h00)
               r_next.cnt = r_reg.cnt - 5'h01;
            if (sar_done)
            begin
               r_next.result = tif.corrected;
               r_next.st = st_wait;
            end
         end
         st_wait:
            r_next.st = st_acq;
         default:
            r_next.st = st_acq;
      endcase
      // negative sampling source
      case (mode_t'(mode))
         mode_single: r_next.nsrc = neg_gnd;
         mode_pseudo: r_next.nsrc = r_next.st == st_acq ?
                                    neg_pin : neg_ref;
         mode_diff:   r_next.nsrc = neg_pin;
         default:     r_next.nsrc = neg_gnd;
      endcase
      // axi write: address and data in either order
      if (s_awvalid && r_reg.awready)
      begin
         r_next.aw_have = 1'b1;
         r_next.aw_addr = s_awaddr;
         r_next.awready = 1'b0;
      end
      if (s_wvalid && r_reg.wready)
      begin
         r_next.w_have = 1'b1;
         r_next.w_data = s_wdata;
         r_next.w_strb = s_wstrb;
         r_next.wready = 1'b0;
      end
      do_wr = r_reg.aw_have && r_reg.w_have && !r_reg.bvalid;
      wa = r_reg.aw_addr;
      wd = r_reg.w_data;
      if (do_wr)
      begin
         r_next.aw_have = 1'b0;
         r_next.w_have = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = 2'b00;
         if (r_reg.w_strb[0])
            case ({wa[7:2], 2'b00})
               ctrl_off:     r_next.ctrl = {3'h0, wd[4:0]};
               pos_sel_off:  r_next.pos_sel = wd[4:0];
               neg_sel_off:  r_next.neg_sel = wd[4:0];
               ref_ctrl_off: r_next.refc = wd[1:0];
               sw_start_off: r_next.sw_req = r_next.sw_req | wd[0];
               offset_off:   r_next.offset[7:0] = wd[7:0];
               gain_off:     r_next.gain[7:0] = wd[7:0];
               result_off:   r_next.bresp = 2'b10;
               default:      r_next.bresp = 2'b10;
            endcase
         if (r_reg.w_strb[1])
            case ({wa[7:2], 2'b00})
               offset_off: r_next.offset[9:8] = wd[9:8];
               gain_off:   r_next.gain[9:8] = wd[9:8];
               default:    ;
            endcase
      end
      // a start request only pends while the single trigger is chosen,
      // so a stale request cannot fire after a later trigger change
      if (trig_t'(r_next.ctrl[2:0]) != trig_single)
         r_next.sw_req = 1'b0;
      if (r_reg.bvalid && s_bready)
      begin
         r_next.bvalid = 1'b0;
         r_next.awready = 1'b1;
         r_next.wready = 1'b1;
      end
      // axi read
      if (s_arvalid && r_reg.arready)
      begin
         r_next.arready = 1'b0;
         r_next.rvalid = 1'b1;
         r_next.rresp = 2'b00;
         case ({s_araddr[7:2], 2'b00})
            ctrl_off:     r_next.rdata = {24'h0, r_reg.ctrl};
            pos_sel_off:  r_next.rdata = {27'h0, r_reg.pos_sel};
            neg_sel_off:  r_next.rdata = {27'h0, r_reg.neg_sel};
            offset_off:   r_next.rdata = {22'h0, r_reg.offset};
            gain_off:     r_next.rdata = {22'h0, r_reg.gain};
            ref_ctrl_off: r_next.rdata = {30'h0, r_reg.refc};
            result_off:   r_next.rdata = {4'h0, r_reg.result, 16'h0};
            sw_start_off: r_next.rdata = {31'h0, r_reg.st != st_acq};
            default:
            begin
               r_next.rdata = 32'h0;
               r_next.rresp = 2'b10;
            end
         endcase
      end
      if (r_reg.rvalid && s_rready)
      begin
         r_next.rvalid = 1'b0;
         r_next.arready = 1'b1;
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r_reg <= '0;
         r_reg.awready <= 1'b1;
         r_reg.wready <= 1'b1;
         r_reg.arready <= 1'b1;
         r_reg.ctrl <= ctrl_rst;
         r_reg.pos_sel <= chan_rst;
         r_reg.neg_sel <= chan_rst;
         r_reg.offset <= trim_rst;
         r_reg.gain <= trim_rst;
         r_reg.refc <= ref_rst;
         r_reg.st <= st_acq;
      end
      else
         r_reg <= r_next;
   end
   assign s_awready = r_reg.awready;
   assign s_wready = r_reg.wready;
   assign s_bvalid = r_reg.bvalid;
   assign s_bresp = r_reg.bresp;
   assign s_arready = r_reg.arready;
   assign s_rvalid = r_reg.rvalid;
   assign s_rresp = r_reg.rresp;
   assign s_rdata = r_reg.rdata;
   assign pos_mux_sel = r_reg.pmux;
   assign pos_mux_valid = r_reg.pval;
   assign neg_mux_sel = r_reg.nmux;
   assign neg_mux_valid = r_reg.nval;
   assign neg_sample_src = r_reg.nsrc;
   // switches open from start until one cycle after the result is latched
   assign sample_switch_closed = r_reg.st == st_acq;
   assign sar_start = r_reg.start;
   assign conv_busy = r_reg.st != st_acq;
   assign int_ref_power_down = r_reg.refc[ref_pd_bit];
   assign ref_pin_connect = r_reg.refc[ref_out_bit];
endmodule : adc_trigger_mux_calibration_ctrl

/* sar_model.sv */
// far-side successive approximation converter model
`timescale 1ns/1ps
module sar_model (
   // control
   input wire logic        aclk,
   input wire logic        sar_start,
   input wire logic [3:0]  dly,
   input wire logic [11:0] code_in,
   // answer
   output logic            sar_done,
   output logic [11:0]     sar_code
);
   int cnt = 0;
   always @(posedge aclk)
   begin
      sar_done <= 1'h0;
      // code is junk outside the done pulse
      sar_code <= ~sar_code;
      if (sar_start)
         cnt <= dly + 1;
      else if (cnt == 1)
      begin
         sar_done <= 1'h1;
         sar_code <= code_in;
         cnt <= 0;
      end
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
endmodule : sar_model

/* test_adc_trigger_mux_calibration_ctrl.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_adc_trigger_mux_calibration_ctrl;
   import adc_ctrl_pkg::*;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [7:0]  s_awaddr = 8'h0, s_araddr = 8'h0;
   logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
   logic        s_arvalid = 1'h0, s_rready = 1'h0;
   logic [31:0] s_wdata = 32'h0, s_rdata, r = 32'hf781;
   logic [3:0]  s_wstrb = 4'hf, trg = 4'h0, dly = 4'h3;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0]  s_bresp, s_rresp, neg_sample_src;
   logic        external_conversion_trigger_pin, timer0_overflow;
   logic        timer1_overflow, programmable_logic_array;
   logic [4:0]  pos_mux_sel, neg_mux_sel;
   logic        pos_mux_valid, neg_mux_valid, sample_switch_closed;
   logic        sar_start, sar_done, int_ref_power_down;
   logic        ref_pin_connect, conv_busy;
   logic [11:0] sar_code, code_in = 12'h0;
   logic [33:0] expq [$];
   logic [7:0]  offs [7] = '{ctrl_off, pos_sel_off, neg_sel_off,
      offset_off, gain_off, ref_ctrl_off, sw_start_off};
   int          num_errors = 0, n_tests = 0, n_start = 0, cyc = 0;
   assign {programmable_logic_array, timer0_overflow, timer1_overflow,
      external_conversion_trigger_pin} = trg;
   adc_trigger_mux_calibration_ctrl uut (.*);
   sar_model far (.*);
   always #4 aclk = ~aclk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic finish_test;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test
   task automatic check(input string nm, input logic [33:0] g, e);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic aw_left, w_left;
      aw_left = 1'h1;
      w_left = 1'h1;
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      while (aw_left || w_left)
      begin
         @(posedge aclk);
         aw_left = aw_left && !s_awready;
         w_left = w_left && !s_wready;
         s_awvalid <= aw_left;
         s_wvalid <= w_left;
      end
      do @(posedge aclk); while (!s_bvalid);
      check("bresp", s_bresp, er);
      s_bready <= 1'h0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      expq.push_back(e);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      do @(posedge aclk); while (!s_arready);
      s_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_rvalid);
      s_rready <= 1'h0;
      @(posedge aclk);
   endtask : rd
   task automatic wait_done;
      int k;
      k = 0;
      while (!sar_done && k < 60)
      begin
         @(posedge aclk);
         k++;
      end
      repeat (3) @(posedge aclk);
   endtask : wait_done
   task automatic conv(input logic [11:0] raw, res);
      code_in <= raw;
      wr(sw_start_off, 32'h1, 2'h0);
      wait_done();
      rd(result_off, {6'h0, res, 16'h0});
   endtask : conv
   // result monitor pairs each answer with the oldest note
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (sar_start)
         n_start <= n_start + 1;
      if (s_rvalid && s_rready)
         check("rdata", {s_rresp, s_rdata}, expq.pop_front());
      if (cyc == 30000)
      begin
         num_errors++;
         finish_test();
      end
   end
   initial
   begin
      int k, n0;
      logic [3:0] sel;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      foreach (offs[i])
         rd(offs[i], 34'h0);
      rd(8'h20, {2'h2, 32'h0});
      wr(result_off, 32'h0, 2'h2);
      for (int i = 0; i < 32; i++)
      begin
         r = lfsr(r);
         wr(pos_sel_off, {r[31:5], i[4:0]}, 2'h0);
         wr(neg_sel_off, {r[26:0], i[4:0]}, 2'h0);
         check("pv", pos_mux_valid, i < 20);
         check("nv", neg_mux_valid, i < 17);
         if (i < 20)
            check("ps", pos_mux_sel, i[4:0]);
         if (i < 17)
            check("ns", neg_mux_sel, i[4:0]);
         rd(pos_sel_off, 34'(i));
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(ref_ctrl_off, {r[31:2], i[1:0]}, 2'h0);
         check("ref", {int_ref_power_down, ref_pin_connect}, i);
         rd(ref_ctrl_off, 34'(i));
      end
      for (int c = 0; c < 8; c++)
      begin
         r = lfsr(r);
         sel = (c == 5) ? 4'h8 : (c < 3) ? 4'h1 << c : 4'h0;
         dly <= 4'h3 + 4'(r[2:0]);
         code_in <= r[27:16];
         wr(ctrl_off, {27'h0, c[0] ? 2'h0 : 2'h2, c[2:0]}, 2'h0);
         // a continuous run may still be converting
         while (conv_busy)
            @(posedge aclk);
         check("acq", neg_sample_src, c[0] ? 2'h0 : 2'h1);
         n0 = n_start;
         trg <= ~sel;
         repeat (2) @(posedge aclk);
         trg <= 4'h0;
         repeat (6) @(posedge aclk);
         check("idle", (n_start - n0) != 0, c == 4);
         if (c > 2 && c != 5)
            wr(sw_start_off, 32'h1, 2'h0);
         trg <= sel;
         repeat (2) @(posedge aclk);
         trg <= 4'h0;
         // continuous mode: wait for a fresh start
         if (c == 4)
            n0 = n_start;
         k = 0;
         while (n_start == n0 && k < 20)
         begin
            @(posedge aclk);
            k++;
         end
         check("start", n_start != n0, c < 6);
         if (c < 6)
         begin
            check("conv", neg_sample_src, c[0] ? 2'h0 : 2'h2);
            wait_done();
            rd(result_off, {6'h0, code_in, 16'h0});
            repeat (12) @(posedge aclk);
            check("again", n_start - n0 > 1, c == 4);
         end
      end
      wr(ctrl_off, 32'h18, 2'h0);
      n0 = n_start;
      trg <= 4'h1;
      repeat (2) @(posedge aclk);
      trg <= 4'h0;
      repeat (6) @(posedge aclk);
      check("blocked", n_start - n0, 0);
      wr(ctrl_off, 32'h08, 2'h0);
      trg <= 4'h1;
      repeat (3) @(posedge aclk);
      trg <= 4'h0;
      check("diff", {conv_busy, neg_sample_src}, 3'h5);
      wait_done();
      wr(ctrl_off, 32'h3, 2'h0);
      dly <= 4'h8;
      wr(pos_sel_off, 32'h11, 2'h0);
      wr(offset_off, 32'h4, 2'h0);
      conv(12'h064, 12'h065);
      wr(offset_off, 32'h3fc, 2'h0);
      conv(12'h064, 12'h063);
      wr(offset_off, 32'h0, 2'h0);
      wr(pos_sel_off, 32'h12, 2'h0);
      wr(gain_off, 32'h8, 2'h0);
      conv(12'h800, 12'h801);
      wr(gain_off, 32'h3f8, 2'h0);
      conv(12'h800, 12'h7ff);
      finish_test();
   end
endmodule : test_adc_trigger_mux_calibration_ctrl
bind adc_trigger_mux_calibration_ctrl adc_ctrl_checker chk (.*);

/* trim_if.sv */
// carries raw sample and trims into the correction unit
`timescale 1ns/1ps
interface trim_if;
   logic        [11:0] raw;
   logic signed [9:0]  offset;
   logic signed [9:0]  gain;
   logic        [11:0] corrected;
   modport ctrl (output raw, output offset, output gain, input corrected);
   modport unit (input raw, input offset, input gain, output corrected);
endinterface : trim_if

/* trim_unit.sv */
// digital offset and gain correction of a 12-bit result
`timescale 1ns/1ps
module trim_unit
   import adc_ctrl_pkg::*;
(
   // correction port
   trim_if.unit t
);
   logic signed [15:0] x_q;
   logic signed [15:0] off_q;
   logic signed [27:0] prod;
   logic signed [15:0] y_q;
   logic signed [11:0] g_q;
   always_comb
   begin
      // quarter lsb steps, clipped to the documented span
      off_q = 16'(signed'(t.offset));
      if (off_q > 16'(offset_lim_q))
         off_q = 16'(offset_lim_q);
      if (off_q < -16'(offset_lim_q))
         off_q = -16'(offset_lim_q);
      x_q = 16'({4'h0, t.raw, 2'b00}) + off_q;
      // gain scales full scale by gain quarter lsb over 4096 lsb
      // clip both signs; an unsigned compare would flip negative gains
      g_q = 12'(signed'(t.gain));
      if (g_q > gain_lim_q)
         g_q = gain_lim_q;
      if (g_q < -gain_lim_q)
         g_q = -gain_lim_q;
      prod = 28'(x_q) * 28'(g_q);
      y_q = x_q + 16'(prod >>> 14);
      if (y_q < 16'sd0)
         t.corrected = 12'h000;
      else if (y_q[15:2] > 14'h0fff)
         t.corrected = 12'hfff;
      else
         t.corrected = y_q[13:2];
   end
endmodule : trim_unit
